/* logic/pswc_defines.svh */
// timing counts and reset values for the power state and wake controller
`ifndef PSWC_DEFINES_SVH
`define PSWC_DEFINES_SVH
`define PSWC_CLK_HZ 40000000
`define PSWC_LONG_PRESS_S 4
`define PSWC_LONG_PRESS_CYC (`PSWC_LONG_PRESS_S * `PSWC_CLK_HZ)
`define PSWC_DEBOUNCE_US 10000
`define PSWC_DEBOUNCE_CYC ((`PSWC_DEBOUNCE_US * (`PSWC_CLK_HZ / 1000000)))
`define PSWC_BLINK_MS 500
`define PSWC_BLINK_CYC (`PSWC_BLINK_MS * (`PSWC_CLK_HZ / 1000))
`define PSWC_TACH_WIN_MS 1000
`define PSWC_TACH_WIN_CYC (`PSWC_TACH_WIN_MS * (`PSWC_CLK_HZ / 1000))
`define PSWC_DUTY_RST 8'h80
`define PSWC_DUTY_STEP 8'h04
`endif

/* logic/pswc_fan_loop.sv */
// closed-loop fan duty control from tachometer pulses
`timescale 1ns/10ps
`include "pswc_defines.svh"
module pswc_fan_loop #(
  parameter int unsigned WIN_CYC = `PSWC_TACH_WIN_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic tach,
  input wire logic [15:0] target_rpm_cnt,
  output logic pwm,
  output logic [15:0] tach_count
);
  typedef struct packed {
    logic tach_q;
    logic [31:0] win;
    logic [15:0] pulses;
    logic [15:0] last;
    logic [7:0] duty;
    logic [7:0] phase;
    logic pwm;
  } pswc_fan_st_t;

  pswc_fan_st_t st;
  pswc_fan_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.tach_q = tach;
    next_st.phase = st.phase + 8'h1;
    next_st.pwm = run && (st.phase < st.duty);
    if (tach && !st.tach_q) begin
      next_st.pulses = st.pulses + 16'h1;
    end
    if (st.win >= WIN_CYC - 1) begin
      next_st.win = 32'h0;
      next_st.pulses = 16'h0;
      next_st.last = st.pulses;
      // speed feedback steers duty
      if (st.pulses < target_rpm_cnt && st.duty <= 8'hff - `PSWC_DUTY_STEP) begin
        next_st.duty = st.duty + `PSWC_DUTY_STEP;
      end else if (st.pulses > target_rpm_cnt && st.duty >= `PSWC_DUTY_STEP) begin
        next_st.duty = st.duty - `PSWC_DUTY_STEP;
      end
    end else begin
      next_st.win = st.win + 32'h1;
    end
    if (!run) begin
      next_st.duty = `PSWC_DUTY_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '{duty: `PSWC_DUTY_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign pwm = st.pwm;
  assign tach_count = st.last;
endmodule

/* logic/pswc_pkg.sv */
// types for the power state and wake controller
package pswc_pkg;
  // sleep state, gray order along the usual path
  typedef enum logic [2:0] {
    PSWC_S0 = 3'h0,
    PSWC_S1 = 3'h1,
    PSWC_S3 = 3'h3,
    PSWC_S4 = 3'h2,
    PSWC_S5 = 3'h6
  } pswc_state_t;

  typedef struct packed {
    logic lan;
    logic pme;
    logic pcie_wake;
    logic rtc_alarm;
    logic serial;
    logic usb;
    logic ps2_any;
    logic ps2_power_key;
  } pswc_wake_t;

  typedef struct packed {
    logic pme_en;
    logic pcie_wake_en;
    logic ps2_s5_key_en;
  } pswc_cfg_t;

  typedef enum logic [1:0] {
    PSWC_PRESS_NONE = 2'h0,
    PSWC_PRESS_SHORT = 2'h1,
    PSWC_PRESS_LONG = 2'h3
  } pswc_press_t;
endpackage

/* logic/pswc_switch_timer.sv */
// power switch debounce and press length measurement
`timescale 1ns/10ps
`include "pswc_defines.svh"
module pswc_switch_timer #(
  parameter int unsigned LONG_CYC = `PSWC_LONG_PRESS_CYC,
  parameter int unsigned DEB_CYC = `PSWC_DEBOUNCE_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sw_pressed,
  output pswc_pkg::pswc_press_t press
);
  typedef struct packed {
    logic stable;
    logic [19:0] deb;
    logic [31:0] held;
    logic long_done;
    pswc_pkg::pswc_press_t press;
  } pswc_sw_st_t;

  pswc_sw_st_t st;
  pswc_sw_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.press = pswc_pkg::PSWC_PRESS_NONE;
    // debounce: level must hold for the whole window
    if (sw_pressed == st.stable) begin
      next_st.deb = 20'h0;
    end else if (st.deb >= 20'(DEB_CYC - 1)) begin
      next_st.deb = 20'h0;
      next_st.stable = sw_pressed;
    end else begin
      next_st.deb = st.deb + 20'h1;
    end
    if (st.stable) begin
      if (!st.long_done && st.held >= LONG_CYC - 1) begin
        next_st.long_done = 1'b1;
        next_st.press = pswc_pkg::PSWC_PRESS_LONG;
      end else if (!st.long_done) begin
        next_st.held = st.held + 32'h1;
      end
      if (!next_st.stable) begin
        if (!st.long_done && next_st.press == pswc_pkg::PSWC_PRESS_NONE) begin
          next_st.press = pswc_pkg::PSWC_PRESS_SHORT;
        end
        next_st.held = 32'h0;
        next_st.long_done = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign press = st.press;
endmodule

/* logic/pswc_top.sv */
// power state and wake controller top
// Functional notes
// - short press toggles off/on, wakes sleep
// - long press forces soft off
// - wake sources qualified per sleep state
// - serial wakes only from S1, S3
// - usb wakes from S1, S3
// - usb power removed in S4, S5
// - any ps2 activity wakes S1, S3
// - S4/S5 ps2 wake needs special key
// - pme wakes only when enabled
// - pcie wake line has enable option
// - S5 wakes work after power restored
// - fan on in S0
// - fan off when off or S1-S5
// - fan speed follows tachometer feedback
// - S3 drops drives and fan, blinks led
// - wake from S3 resumes saved context
// - lan wake packet request powers up
// - standby led lit while standby present
`timescale 1ns/10ps
`include "pswc_defines.svh"
module pswc_top #(
  parameter int unsigned LONG_CYC = `PSWC_LONG_PRESS_CYC,
  parameter int unsigned DEB_CYC = `PSWC_DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYC = `PSWC_BLINK_CYC,
  parameter int unsigned WIN_CYC = `PSWC_TACH_WIN_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic standby_ok,
  input wire logic power_switch,
  input wire pswc_pkg::pswc_wake_t wake_req,
  input wire pswc_pkg::pswc_cfg_t cfg,
  input wire logic sleep_req,
  input wire pswc_pkg::pswc_state_t sleep_target,
  input wire logic fan_tach,
  input wire logic [15:0] fan_target,
  output pswc_pkg::pswc_state_t sys_state,
  output logic main_power_on,
  output logic resume_ctx,
  output logic drive_power_on,
  output logic usb_power_on,
  output logic fan_on,
  output logic fan_pwm,
  output logic [15:0] fan_speed,
  output logic front_led,
  output logic standby_led,
  output logic wake_event
);
  // ==========================================================
  // state record
  typedef struct packed {
    pswc_pkg::pswc_state_t state;
    logic resume;
    logic wake;
    logic [31:0] blink_cnt;
    logic blink;
    logic main_pwr;
    logic drive_pwr;
    logic usb_pwr;
    logic fan;
    logic led;
    logic sb_led;
  } pswc_top_st_t;

  pswc_top_st_t st;
  pswc_top_st_t next_st;
  pswc_pkg::pswc_press_t press;
  logic fan_pwm_w;
  logic [15:0] fan_speed_w;
  logic wake_hit;

  // ==========================================================
  // wake qualification per source and state
  function automatic logic pswc_is_shallow(input pswc_pkg::pswc_state_t s);
    pswc_is_shallow = (s == pswc_pkg::PSWC_S1) || (s == pswc_pkg::PSWC_S3);
  endfunction

  function automatic logic pswc_is_deep(input pswc_pkg::pswc_state_t s);
    pswc_is_deep = (s == pswc_pkg::PSWC_S4) || (s == pswc_pkg::PSWC_S5);
  endfunction

  function automatic logic pswc_wake_ok(input pswc_pkg::pswc_state_t s,
                                        input pswc_pkg::pswc_wake_t w,
                                        input pswc_pkg::pswc_cfg_t c);
    logic sleeping;
    logic ps2_ok;
    sleeping = pswc_is_shallow(s) || pswc_is_deep(s);
    ps2_ok = pswc_is_shallow(s) ? (w.ps2_any || w.ps2_power_key)
           : (c.ps2_s5_key_en && w.ps2_power_key);
    pswc_wake_ok = sleeping && (w.lan
                 || (w.pme && c.pme_en)
                 || (w.pcie_wake && c.pcie_wake_en)
                 || ps2_ok)
                 || (pswc_is_deep(s) && w.rtc_alarm)
                 || (pswc_is_shallow(s) && w.serial)
                 || (pswc_is_shallow(s) && w.usb);
  endfunction

  assign wake_hit = pswc_wake_ok(st.state, wake_req, cfg);

  // ==========================================================
  // submodules
  pswc_switch_timer #(
    .LONG_CYC(LONG_CYC),
    .DEB_CYC(DEB_CYC)
  ) u_switch (
    .core_clk(core_clk),
    .srst(srst),
    .sw_pressed(power_switch),
    .press(press)
  );

  pswc_fan_loop #(
    .WIN_CYC(WIN_CYC)
  ) u_fan (
    .core_clk(core_clk),
    .srst(srst),
    .run(st.fan),
    .tach(fan_tach),
    .target_rpm_cnt(fan_target),
    .pwm(fan_pwm_w),
    .tach_count(fan_speed_w)
  );

  // ==========================================================
  // state transitions
  always_comb begin
    next_st = st;
    next_st.wake = 1'b0;
    // state is held in standby logic; S5 survives power loss
    unique case (st.state)
      pswc_pkg::PSWC_S0: begin
        if (press == pswc_pkg::PSWC_PRESS_SHORT || press == pswc_pkg::PSWC_PRESS_LONG) begin
          next_st.state = pswc_pkg::PSWC_S5;
          next_st.resume = 1'b0;
        end else if (sleep_req && sleep_target != pswc_pkg::PSWC_S0) begin
          next_st.state = sleep_target;
          next_st.resume = 1'b0;
        end
      end
      pswc_pkg::PSWC_S1, pswc_pkg::PSWC_S3, pswc_pkg::PSWC_S4: begin
        if (press == pswc_pkg::PSWC_PRESS_LONG) begin
          next_st.state = pswc_pkg::PSWC_S5;
        end else if (press == pswc_pkg::PSWC_PRESS_SHORT || wake_hit) begin
          next_st.state = pswc_pkg::PSWC_S0;
          next_st.wake = 1'b1;
          next_st.resume = (st.state != pswc_pkg::PSWC_S4);
        end
      end
      pswc_pkg::PSWC_S5: begin
        if (press == pswc_pkg::PSWC_PRESS_SHORT || wake_hit) begin
          next_st.state = pswc_pkg::PSWC_S0;
          next_st.wake = 1'b1;
          next_st.resume = 1'b0;
        end
      end
      default: begin
        next_st.state = pswc_pkg::PSWC_S5;
      end
    endcase

    // blink timer runs only in S3
    if (next_st.state == pswc_pkg::PSWC_S3) begin
      if (st.blink_cnt >= BLINK_CYC - 1) begin
        next_st.blink_cnt = 32'h0;
        next_st.blink = !st.blink;
      end else begin
        next_st.blink_cnt = st.blink_cnt + 32'h1;
      end
    end else begin
      next_st.blink_cnt = 32'h0;
      next_st.blink = 1'b0;
    end

    // outputs from the next state so they track it on the same edge
    next_st.main_pwr = (next_st.state == pswc_pkg::PSWC_S0)
                    || (next_st.state == pswc_pkg::PSWC_S1);
    next_st.drive_pwr = next_st.main_pwr;
    next_st.fan = (next_st.state == pswc_pkg::PSWC_S0);
    next_st.usb_pwr = !pswc_is_deep(next_st.state);
    next_st.led = (next_st.state == pswc_pkg::PSWC_S3) ? next_st.blink
                : next_st.main_pwr;
    next_st.sb_led = standby_ok;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '{state: pswc_pkg::PSWC_S5, usb_pwr: 1'b0, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign sys_state = st.state;
  assign main_power_on = st.main_pwr;
  assign resume_ctx = st.resume;
  assign drive_power_on = st.drive_pwr;
  assign usb_power_on = st.usb_pwr;
  assign fan_on = st.fan;
  assign fan_pwm = fan_pwm_w;
  assign fan_speed = fan_speed_w;
  assign front_led = st.led;
  assign standby_led = st.sb_led;
  assign wake_event = st.wake;
endmodule

/* verification/pswc_fan_model.sv */
// fan model turning drive pulses into tachometer edges
`timescale 1ns/10ps
module pswc_fan_model (
  input wire logic core_clk,
  input wire logic pwm,
  input wire logic slow,
  output logic tach
);
  // ==========
  // rotor
  logic [2:0] acc = 3'h0;
  // speed follows drive duty, half rate when slow
  always_ff @(posedge core_clk) begin
    if (pwm) begin
      acc <= acc + (slow ? 3'h1 : 3'h2);
    end
  end
  assign tach = acc[2];
endmodule

/* verification/pswc_top_monitor.sv */
// concurrent checks on the ports of the power state and wake controller
`timescale 1ns/10ps
module pswc_top_monitor #(
  parameter int unsigned DEB_CYC = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic standby_ok,
  input wire logic power_switch,
  input wire pswc_pkg::pswc_wake_t wake_req,
  input wire pswc_pkg::pswc_cfg_t cfg,
  input wire pswc_pkg::pswc_state_t sys_state,
  input wire logic drive_power_on,
  input wire logic usb_power_on,
  input wire logic fan_on,
  input wire logic fan_pwm,
  input wire logic standby_led,
  input wire logic wake_event
);
  // ==========
  // helpers
  logic [31:0] quiet;
  logic deep;
  logic shallow;
  // cycles since the switch was last seen pressed
  always_ff @(posedge core_clk) begin
    if (srst || power_switch) begin
      quiet <= 32'h0;
    end else if (quiet <= DEB_CYC + 8) begin
      quiet <= quiet + 32'h1;
    end
  end
  assign deep = (sys_state == pswc_pkg::PSWC_S4) || (sys_state == pswc_pkg::PSWC_S5);
  assign shallow = (sys_state == pswc_pkg::PSWC_S1) || (sys_state == pswc_pkg::PSWC_S3);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_enter_s0;
    (sys_state == pswc_pkg::PSWC_S0) && ($past(sys_state) != pswc_pkg::PSWC_S0);
  endsequence
  sequence s_pulse_gone;
    !wake_event;
  endsequence
  // ==========
  // assertions
  a_fan_in_s0: assert property (sys_state == pswc_pkg::PSWC_S0 |-> fan_on)
    else $error("fan off while working");
  a_fan_off_low: assert property (sys_state != pswc_pkg::PSWC_S0 |-> !fan_on)
    else $error("fan on outside working state");
  a_usb_deep_off: assert property (deep |-> !usb_power_on)
    else $error("usb powered in deep sleep");
  a_s3_dark: assert property (sys_state == pswc_pkg::PSWC_S3 |-> !drive_power_on && !fan_on)
    else $error("drives or fan powered in suspend");
  a_standby_follow: assert property (!$past(srst) |-> standby_led == $past(standby_ok))
    else $error("standby led does not follow standby rail");
  a_pwm_idle: assert property (!fan_on && $past(!fan_on) |-> !fan_pwm)
    else $error("fan drive active while fan off");
  a_wake_pulse: assert property (wake_event |-> s_enter_s0 ##1 s_pulse_gone)
    else $error("wake pulse without entry to working state");
  a_entry_pulse: assert property (s_enter_s0 |-> wake_event)
    else $error("working state entered without wake pulse");
  a_shallow_wake: assert property (shallow && (wake_req.serial || wake_req.usb ||
      wake_req.ps2_any) |=> sys_state == pswc_pkg::PSWC_S0)
    else $error("activity did not wake from light sleep");
  a_deep_refuse: assert property (deep && quiet > DEB_CYC + 4 && !wake_req.lan &&
      !wake_req.rtc_alarm && !(wake_req.ps2_power_key && cfg.ps2_s5_key_en) &&
      !(wake_req.pme && cfg.pme_en) &&
      !(wake_req.pcie_wake && cfg.pcie_wake_en) |=> $stable(sys_state))
    else $error("deep sleep left on a refused source");
endmodule

bind pswc_top pswc_top_monitor #(.DEB_CYC(DEB_CYC)) u_mon (.core_clk(core_clk),
  .srst(srst), .standby_ok(standby_ok), .power_switch(power_switch), .wake_req(wake_req),
  .cfg(cfg), .sys_state(sys_state), .drive_power_on(drive_power_on),
  .usb_power_on(usb_power_on), .fan_on(fan_on), .fan_pwm(fan_pwm),
  .standby_led(standby_led), .wake_event(wake_event));

/* verification/pswc_top_tb_top.sv */
// self-checking bench for the power state and wake controller
`timescale 1ns/10ps
module pswc_top_tb_top;
  // ==========
  // signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic standby_ok = 1'b1;
  logic power_switch = 1'b0;
  pswc_pkg::pswc_wake_t wake_req = '0;
  pswc_pkg::pswc_cfg_t cfg = '0;
  logic sleep_req = 1'b0;
  pswc_pkg::pswc_state_t sleep_target = pswc_pkg::PSWC_S1;
  logic fan_tach;
  logic slow = 1'b0;
  logic [15:0] fan_target = 16'h0010;
  pswc_pkg::pswc_state_t sys_state;
  logic main_power_on, resume_ctx, drive_power_on, usb_power_on, fan_on, fan_pwm;
  logic [15:0] fan_speed;
  logic front_led, standby_led, wake_event, led0;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int k;
  pswc_pkg::pswc_state_t st;
  pswc_pkg::pswc_state_t sl[4] = '{pswc_pkg::PSWC_S1, pswc_pkg::PSWC_S3,
    pswc_pkg::PSWC_S4, pswc_pkg::PSWC_S5};

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  pswc_top #(.LONG_CYC(200), .DEB_CYC(4), .BLINK_CYC(8), .WIN_CYC(64)) dut (
    .core_clk(core_clk), .srst(srst), .standby_ok(standby_ok), .power_switch(power_switch),
    .wake_req(wake_req), .cfg(cfg), .sleep_req(sleep_req), .sleep_target(sleep_target),
    .fan_tach(fan_tach), .fan_target(fan_target), .sys_state(sys_state),
    .main_power_on(main_power_on), .resume_ctx(resume_ctx), .drive_power_on(drive_power_on),
    .usb_power_on(usb_power_on), .fan_on(fan_on), .fan_pwm(fan_pwm), .fan_speed(fan_speed),
    .front_led(front_led), .standby_led(standby_led), .wake_event(wake_event));

  pswc_fan_model fan (.core_clk(core_clk), .pwm(fan_pwm), .slow(slow), .tach(fan_tach));

  // ==========
  // tasks
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk_st(input pswc_pkg::pswc_state_t got, input pswc_pkg::pswc_state_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic press(input int n);
    power_switch = 1'b1;
    tick(n);
    power_switch = 1'b0;
    tick(12);
  endtask
  task automatic sleep_to(input pswc_pkg::pswc_state_t t);
    sleep_target = t;
    sleep_req = 1'b1;
    tick(1);
    sleep_req = 1'b0;
    tick(2);
  endtask
  task automatic pulse(input int b);
    wake_req = pswc_pkg::pswc_wake_t'(8'h01 << b);
    tick(1);
    wake_req = '0;
    tick(2);
  endtask
  function automatic logic exp_wake(input pswc_pkg::pswc_state_t s, input int b,
      input pswc_pkg::pswc_cfg_t c);
    logic deep;
    deep = (s == pswc_pkg::PSWC_S4) || (s == pswc_pkg::PSWC_S5);
    case (b)
      7: return 1'b1;
      0: return !deep || c.ps2_s5_key_en;
      6: return c.pme_en;
      5: return c.pcie_wake_en;
      4: return deep;
      default: return !deep;
    endcase
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========
  // sequence
  initial begin
    void'($urandom(32'hee0f));
    tick(16);
    srst = 1'b0;
    tick(2);
    chk_st(sys_state, pswc_pkg::PSWC_S5);
    chk_b(standby_led, 1'b1);
    press(8);
    chk_st(sys_state, pswc_pkg::PSWC_S0);
    chk_b(fan_on, 1'b1);
    for (int i = 0; i < 2000 && fan_speed === 16'h0; i++) tick(1);
    chk_b(|fan_speed, 1'b1);
    sleep_to(pswc_pkg::PSWC_S3);
    chk_b(drive_power_on, 1'b0);
    led0 = front_led;
    tick(8);
    chk_b(front_led, !led0);
    press(6);
    chk_st(sys_state, pswc_pkg::PSWC_S0);
    chk_b(resume_ctx, 1'b1);
    press(230);
    chk_st(sys_state, pswc_pkg::PSWC_S5);
    press(6);
    for (int i = 0; i < 40; i++) begin
      st = sl[$urandom_range(3)];
      k = $urandom_range(7);
      slow = 1'($urandom_range(1));
      cfg = pswc_pkg::pswc_cfg_t'(3'($urandom_range(7)));
      if (k == 0 && i[0]) cfg.ps2_s5_key_en = 1'b1;
      sleep_to(st);
      chk_st(sys_state, st);
      chk_b(usb_power_on, st == pswc_pkg::PSWC_S1 || st == pswc_pkg::PSWC_S3);
      chk_b(main_power_on, st == pswc_pkg::PSWC_S1);
      pulse(k);
      if (exp_wake(st, k, cfg)) begin
        chk_st(sys_state, pswc_pkg::PSWC_S0);
        chk_b(resume_ctx, st == pswc_pkg::PSWC_S1 || st == pswc_pkg::PSWC_S3);
      end else begin
        chk_st(sys_state, st);
        pulse(7);
      end
    end
    standby_ok = 1'b0;
    tick(2);
    chk_b(standby_led, 1'b0);
    wrap_up();
  end
endmodule
